// >>> rtl/lvtc_pkg.sv
/*
  Constants, register map and carrier types for the drive-voltage and
  temperature control block.
  Assumes a 100 MHz ref_clk and an APB master with 32-bit data.
*/
// How it works
// - Pump enable clear: external supply used, internal generation held off.
// - External supply selected: compensation term never applied.
// - External supply selected: programmed code does not reach the output.
// - Pump enable set: pump runs and drives the voltage output.
// - Multiplier field is separate from the enable bit.
// - Output code is programmed code plus compensation, 0.03 V steps over 3.99 V.
// - Compensation term is 9-bit two's complement, zero at 20 degrees.
// - Any code 0..1ff accepted; resulting voltage clamped to 12 V.
// - Temperature is an 8-bit code readable by software.
// - Temperature equals code times 0.6275 minus 40 degrees.
// - Code reads ff while no measurement is available.
// - One measurement takes about 8 ms.
// - Measurement repeats each second while measure enable is set.
// - Filter enable bit routes samples through or around the filter.
// - Filter damps oscillation, adding delay to the reading.
// - Compensation only when the compensation enable bit is set.
// - Compensation skipped unless limit1 < limit2 and limit3 < limit4.
// - Reset leaves measurement, filter, pump and compensation disabled.
package lvtc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register byte offsets
  localparam logic [11:0] OFS_CTRL = 12'h000;
  localparam logic [11:0] OFS_VPROG = 12'h004;
  localparam logic [11:0] OFS_LIMITS = 12'h008;
  localparam logic [11:0] OFS_COMP = 12'h00c;
  localparam logic [11:0] OFS_TEMP = 12'h010;
  localparam logic [11:0] OFS_VOUT = 12'h014;

  // Control field positions
  localparam int CTRL_PUMP_EN = 0;
  localparam int CTRL_MULT_LO = 1;
  localparam int CTRL_MEAS_EN = 4;
  localparam int CTRL_FILT_EN = 5;
  localparam int CTRL_COMP_EN = 6;
  localparam int CTRL_OSC_EN = 7;
  localparam logic [7:0] CTRL_RESET = 8'h00;

  // Codes and limits
  localparam logic [7:0] TEMP_NONE = 8'hff;
  localparam logic [8:0] VPROG_RESET = 9'h000;
  localparam logic [8:0] COMP_RESET = 9'h000;
  localparam logic [8:0] VCODE_MAX = 9'h1ff;
  // 12 V limit: (12.00 - 3.99) / 0.03 = 267 steps
  localparam int VOUT_LIMIT_MV = 12000;
  localparam int VOUT_OFFSET_MV = 3990;
  localparam int VOUT_STEP_MV = 30;
  localparam logic [9:0] VCODE_LIMIT = 10'((VOUT_LIMIT_MV - VOUT_OFFSET_MV) / VOUT_STEP_MV);

  // Timing
  localparam int CLK_HZ = 100_000_000;
  localparam int MEAS_TIME_MS = 8;
  localparam int MEAS_PERIOD_MS = 1000;
  localparam int MEAS_CYCLES = CLK_HZ / 1000 * MEAS_TIME_MS;
  localparam int PERIOD_CYCLES = CLK_HZ / 1000 * MEAS_PERIOD_MS;

  // Filter strength: new = old + (sample - old) / 2^FILT_SHIFT
  localparam int FILT_SHIFT = 2;

  ////////////////////////////////////////////////////////////////////////////
  // Carrier types
  typedef struct packed {
    logic pump_enable_bit;
    logic [2:0] pump_multiplier_field;
    logic measure_enable_bit;
    logic temp_filter_enable_bit;
    logic compensation_enable_bit;
    logic osc_enable;
  } lvtc_ctrl_t;

  typedef struct packed {
    logic [7:0] t1;
    logic [7:0] t2;
    logic [7:0] t3;
    logic [7:0] t4;
  } lvtc_limits_t;

  typedef enum logic [1:0] {
    MS_IDLE,
    MS_CONVERT,
    MS_WAIT
  } lvtc_meas_state_t;

endpackage

// >>> rtl/lvtc_top.sv
/*
  Drive-voltage and temperature control with an APB register slave.
  Assumes an analog sensor that delivers an 8-bit raw sample on request,
  and an analog pump that follows the code it is given.
*/
// Chosen here: the APB register port and the register offsets.
`timescale 1ns/1ps
module lvtc_top #(
  parameter int MEAS_CYCLES = lvtc_pkg::MEAS_CYCLES,
  parameter int PERIOD_CYCLES = lvtc_pkg::PERIOD_CYCLES
) (
  input wire logic ref_clk, // 100 MHz clock
  input wire logic reset, // Synchronous reset, active high
  input wire logic psel, // APB select
  input wire logic penable, // APB access phase
  input wire logic pwrite, // APB write
  input wire logic [11:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error
  input wire logic [7:0] sensor_raw, // Raw temperature sample
  output logic sensor_start, // Sensor convert request
  output logic pump_run, // Charge pump running
  output logic [2:0] pump_mult, // Pump multiplication factor
  output logic [9:0] drive_code, // Code to the voltage regulator
  output logic use_ext_supply // Drive supply input pin selected
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  lvtc_pkg::lvtc_ctrl_t ctrl_r;
  lvtc_pkg::lvtc_limits_t limits_r;
  lvtc_pkg::lvtc_meas_state_t ms_r;
  logic [8:0] vprog_r;
  logic [8:0] compensation_term_r;
  logic [7:0] temperature_code_r;
  logic [7:0] filt_r;
  logic filt_valid_r;
  logic meas_en_d_r;
  logic [31:0] cnt_r;
  logic [31:0] rdata_nxt;
  logic wr_acc;
  logic hit;
  logic comp_ok;
  logic signed [10:0] sum;
  logic [9:0] sat_code;
  logic [7:0] filt_nxt;
  logic signed [9:0] filt_diff;

  ////////////////////////////////////////////////////////////////////////////
  // APB decode; single-cycle access, unmapped addresses flag an error
  assign wr_acc = psel && penable && pwrite;
  assign pready = 1'b1;
  assign hit = (paddr == lvtc_pkg::OFS_CTRL) || (paddr == lvtc_pkg::OFS_VPROG)
    || (paddr == lvtc_pkg::OFS_LIMITS) || (paddr == lvtc_pkg::OFS_COMP)
    || (paddr == lvtc_pkg::OFS_TEMP) || (paddr == lvtc_pkg::OFS_VOUT);
  assign pslverr = psel && penable && !hit;

  // Control register
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      ctrl_r <= lvtc_pkg::CTRL_RESET;
    end
    else if (wr_acc && paddr == lvtc_pkg::OFS_CTRL)
    begin
      ctrl_r.pump_enable_bit <= pwdata[lvtc_pkg::CTRL_PUMP_EN];
      ctrl_r.pump_multiplier_field <= pwdata[lvtc_pkg::CTRL_MULT_LO +: 3];
      ctrl_r.measure_enable_bit <= pwdata[lvtc_pkg::CTRL_MEAS_EN];
      ctrl_r.temp_filter_enable_bit <= pwdata[lvtc_pkg::CTRL_FILT_EN];
      ctrl_r.compensation_enable_bit <= pwdata[lvtc_pkg::CTRL_COMP_EN];
      ctrl_r.osc_enable <= pwdata[lvtc_pkg::CTRL_OSC_EN];
    end
  end

  // Programmed voltage, limits and compensation term; full 0..1ff accepted
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      vprog_r <= lvtc_pkg::VPROG_RESET;
      limits_r <= '0;
      compensation_term_r <= lvtc_pkg::COMP_RESET;
    end
    else if (wr_acc)
    begin
      if (paddr == lvtc_pkg::OFS_VPROG)
      begin
        vprog_r <= pwdata[8:0];
      end
      if (paddr == lvtc_pkg::OFS_LIMITS)
      begin
        limits_r <= pwdata;
      end
      if (paddr == lvtc_pkg::OFS_COMP)
      begin
        compensation_term_r <= pwdata[8:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Voltage code: sum, saturate, clamp to the 12 V limit
  assign comp_ok = ctrl_r.compensation_enable_bit && ctrl_r.pump_enable_bit
    && (limits_r.t1 < limits_r.t2) && (limits_r.t3 < limits_r.t4);
  assign sum = $signed({2'b00, vprog_r})
    + (comp_ok ? 11'(signed'(compensation_term_r)) : 11'sd0);

  always_comb
  begin
    if (sum < 11'sd0)
    begin
      sat_code = 10'h000;
    end
    else if (sum > $signed({1'b0, lvtc_pkg::VCODE_LIMIT}))
    begin
      sat_code = lvtc_pkg::VCODE_LIMIT;
    end
    else
    begin
      sat_code = sum[9:0];
    end
  end

  // Outputs to the analog pump
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      pump_run <= 1'b0;
      pump_mult <= 3'h0;
      drive_code <= 10'h000;
      use_ext_supply <= 1'b1;
    end
    else
    begin
      pump_run <= ctrl_r.pump_enable_bit;
      pump_mult <= ctrl_r.pump_multiplier_field;
      use_ext_supply <= !ctrl_r.pump_enable_bit;
      drive_code <= ctrl_r.pump_enable_bit ? sat_code : 10'h000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Measurement sequencer: convert for MEAS_CYCLES, wait rest of period
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      ms_r <= lvtc_pkg::MS_IDLE;
      cnt_r <= 32'h0000_0000;
      meas_en_d_r <= 1'b0;
    end
    else
    begin
      meas_en_d_r <= ctrl_r.measure_enable_bit;
      if (!ctrl_r.measure_enable_bit)
      begin
        ms_r <= lvtc_pkg::MS_IDLE;
        cnt_r <= 32'h0000_0000;
      end
      else
      begin
        unique case (ms_r)
          lvtc_pkg::MS_IDLE:
          begin
            if (!meas_en_d_r)
            begin
              ms_r <= lvtc_pkg::MS_CONVERT;
              cnt_r <= 32'h0000_0000;
            end
          end
          lvtc_pkg::MS_CONVERT:
          begin
            cnt_r <= cnt_r + 32'h1;
            if (cnt_r == 32'(MEAS_CYCLES - 1))
            begin
              ms_r <= lvtc_pkg::MS_WAIT;
            end
          end
          lvtc_pkg::MS_WAIT:
          begin
            cnt_r <= cnt_r + 32'h1;
            if (cnt_r == 32'(PERIOD_CYCLES - 1))
            begin
              ms_r <= lvtc_pkg::MS_CONVERT;
              cnt_r <= 32'h0000_0000;
            end
          end
        endcase
      end
    end
  end

  assign sensor_start = (ms_r == lvtc_pkg::MS_CONVERT) && (cnt_r == 32'h0);

  ////////////////////////////////////////////////////////////////////////////
  // Filter: first-order smoothing, seeded by the first sample
  assign filt_diff = $signed({2'b00, sensor_raw}) - $signed({2'b00, filt_r});
  assign filt_nxt = filt_valid_r
    ? 8'(filt_r + 8'(filt_diff >>> lvtc_pkg::FILT_SHIFT))
    : sensor_raw;

  // Result capture at end of conversion
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      temperature_code_r <= lvtc_pkg::TEMP_NONE;
      filt_r <= 8'h00;
      filt_valid_r <= 1'b0;
    end
    else if (ctrl_r.measure_enable_bit && !meas_en_d_r)
    begin
      temperature_code_r <= lvtc_pkg::TEMP_NONE;
      filt_valid_r <= 1'b0;
    end
    else if (ms_r == lvtc_pkg::MS_CONVERT && cnt_r == 32'(MEAS_CYCLES - 1))
    begin
      filt_r <= filt_nxt;
      filt_valid_r <= 1'b1;
      temperature_code_r <= ctrl_r.temp_filter_enable_bit ? filt_nxt : sensor_raw;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read mux and registered read data
  always_comb
  begin
    rdata_nxt = 32'h0000_0000;
    unique case (paddr)
      lvtc_pkg::OFS_CTRL: rdata_nxt = {24'h0, ctrl_r.osc_enable,
        ctrl_r.compensation_enable_bit, ctrl_r.temp_filter_enable_bit,
        ctrl_r.measure_enable_bit, ctrl_r.pump_multiplier_field, ctrl_r.pump_enable_bit};
      lvtc_pkg::OFS_VPROG: rdata_nxt = {23'h0, vprog_r};
      lvtc_pkg::OFS_LIMITS: rdata_nxt = limits_r;
      lvtc_pkg::OFS_COMP: rdata_nxt = {23'h0, compensation_term_r};
      lvtc_pkg::OFS_TEMP: rdata_nxt = {24'h0, temperature_code_r};
      lvtc_pkg::OFS_VOUT: rdata_nxt = {22'h0, drive_code};
      default: rdata_nxt = 32'h0000_0000;
    endcase
  end

  // Read data is valid in the access phase: sample address in setup
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      prdata <= 32'h0000_0000;
    end
    else if (psel && !penable && !pwrite)
    begin
      prdata <= rdata_nxt;
    end
  end

endmodule // lvtc_top

// >>> tb/lvtc_checker.sv
/*
  Port assertions for the drive-voltage and temperature control block.
  Assumes it is bound into lvtc_top and sees only its ports.
*/
`timescale 1ns/1ps
module lvtc_checker #(
  parameter int MEAS_CYCLES = 10,
  parameter int PERIOD_CYCLES = 40
) (
  input wire logic ref_clk, // Clock
  input wire logic reset, // Sync reset
  input wire logic psel, // APB select
  input wire logic penable, // APB access
  input wire logic pready, // APB ready
  input wire logic pslverr, // APB error
  input wire logic sensor_start, // Convert pulse
  input wire logic pump_run, // Pump running
  input wire logic use_ext_supply, // External supply
  input wire logic [9:0] drive_code // Regulator code
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  ////////////////////////////////////////////////////////////////////////////
  // Supply and code relations, convert spacing and APB handshake
  a_supply_select: assert property (use_ext_supply == !pump_run)
    else $error("supply select and pump state disagree");
  a_reset_state: assert property ($past(reset) |-> use_ext_supply && !pump_run &&
    drive_code == 10'h000) else $error("state after reset wrong");
  a_ext_no_code: assert property (use_ext_supply && $past(use_ext_supply) |->
    drive_code == 10'h000) else $error("code present on external supply");
  a_code_limit: assert property (drive_code <= lvtc_pkg::VCODE_LIMIT)
    else $error("drive code above limit");
  a_code_needs_pump: assert property (drive_code != 10'h000 |-> pump_run)
    else $error("code without pump");
  a_start_spacing: assert property (sensor_start |=> !sensor_start [*8])
    else $error("conversions too close");
  a_slverr_access: assert property (pslverr |-> psel && penable)
    else $error("error outside access phase");
  a_ready_const: assert property (psel && penable |-> pready)
    else $error("ready missing in access");

  // Main scenarios
  c_start: cover property (sensor_start);
  c_slverr: cover property (pslverr);
  c_clamp: cover property (drive_code == lvtc_pkg::VCODE_LIMIT);
endmodule // lvtc_checker

bind lvtc_top lvtc_checker #(.MEAS_CYCLES(MEAS_CYCLES), .PERIOD_CYCLES(PERIOD_CYCLES))
  lvtc_checker_i (.ref_clk(ref_clk), .reset(reset), .psel(psel), .penable(penable),
  .pready(pready), .pslverr(pslverr), .sensor_start(sensor_start), .pump_run(pump_run),
  .use_ext_supply(use_ext_supply), .drive_code(drive_code));

// >>> tb/lvtc_sensor_model.sv
/*
  Temperature sensor stand-in: answers each convert pulse with a level.
  Assumes the block samples within HOLD cycles of the pulse.
*/
`timescale 1ns/1ps
module lvtc_sensor_model #(
  parameter int HOLD = 14
) (
  input wire logic ref_clk, // Clock
  input wire logic sensor_start, // Convert pulse
  input wire logic [7:0] level, // Sample to return
  output logic [7:0] sensor_raw // Raw sample
);
  int cnt = 0;
  logic [7:0] junk = 8'h00;
  // Valid window after a pulse, changing junk outside it
  always_ff @(posedge ref_clk)
  begin
    cnt <= sensor_start ? HOLD : (cnt > 0 ? cnt - 1 : 0);
    junk <= junk + 8'h5b;
  end
  assign sensor_raw = (cnt > 0) ? level : junk;
endmodule // lvtc_sensor_model

// >>> tb/lvtc_top_tb.sv
/*
  Bench for lvtc_top: APB register sequences and measurement runs.
  Assumes short measurement counts set through parameters.
*/
`timescale 1ns/1ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin fail_count++; \
  $display("wrong value at %0t: %h expected %h", $time, a, b); end end
module lvtc_top_tb;
  localparam int MEAS = 10;
  localparam int PER = 40;
  localparam logic [31:0] LIM = 32'h0a141e28;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rdat;
  logic pready, pslverr, sensor_start, pump_run, use_ext_supply, rerr;
  logic [7:0] sensor_raw, level = 8'h80;
  logic [2:0] pump_mult;
  logic [9:0] drive_code;
  int fail_count = 0;
  int num_checks = 0;
  int cyc = 0;
  int t0 = 0;
  // Clock runs for the whole test
  always #5 ref_clk = ~ref_clk;
  // Free-running cycle count for period checks
  always @(posedge ref_clk)
  begin
    cyc <= cyc + 1;
  end
  lvtc_top #(.MEAS_CYCLES(MEAS), .PERIOD_CYCLES(PER)) lvtc_top_i (.ref_clk(ref_clk),
    .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sensor_raw(sensor_raw), .sensor_start(sensor_start), .pump_run(pump_run),
    .pump_mult(pump_mult), .drive_code(drive_code), .use_ext_supply(use_ext_supply));
  lvtc_sensor_model lvtc_sensor_model_i (.ref_clk(ref_clk), .sensor_start(sensor_start),
    .level(level), .sensor_raw(sensor_raw));

  ////////////////////////////////////////////////////////////////////////////
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // One APB transfer, held until ready is seen
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge ref_clk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1)
    begin
      fail_count++;
      end_of_test();
    end
    else
    begin
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    `CHK(rdat, e)
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  // Control, limits, code and term, then the resulting drive code
  task automatic vt(input logic [31:0] c, l, v, t, input logic [9:0] e);
    apb(1'b1, lvtc_pkg::OFS_CTRL, c);
    apb(1'b1, lvtc_pkg::OFS_LIMITS, l);
    apb(1'b1, lvtc_pkg::OFS_VPROG, v);
    apb(1'b1, lvtc_pkg::OFS_COMP, t);
    wt(2);
    `CHK(drive_code, e)
  endtask
  // Bounded wait for a convert pulse
  task automatic wstart();
    int n;
    n = 0;
    while (sensor_start !== 1'b1 && n < 100)
    begin
      @(posedge ref_clk);
      n++;
    end
    if (sensor_start !== 1'b1)
    begin
      fail_count++;
      end_of_test();
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    wt(8);
    reset <= 1'b0;
    rd(lvtc_pkg::OFS_CTRL, 32'h0);
    rd(lvtc_pkg::OFS_TEMP, 32'hff);
    vt(32'h40, LIM, 32'h50, 32'h1f6, 10'h000);
    vt(32'h4b, LIM, 32'h50, 32'h1f6, 10'h046);
    vt(32'h4b, 32'h140a1e28, 32'h50, 32'h1f6, 10'h050);
    vt(32'h4b, 32'h0a14281e, 32'h50, 32'h1f6, 10'h050);
    vt(32'h0b, LIM, 32'h50, 32'h1f6, 10'h050);
    vt(32'h4b, LIM, 32'h1ff, 32'h00a, 10'h10b);
    rd(lvtc_pkg::OFS_VOUT, 32'h10b);
    vt(32'h4b, LIM, 32'h5, 32'h1f6, 10'h000);
    rd(lvtc_pkg::OFS_LIMITS, LIM);
    rd(lvtc_pkg::OFS_VPROG, 32'h5);
    rd(lvtc_pkg::OFS_COMP, 32'h1f6);
    for (int m = 0; m < 8; m++)
    begin
      apb(1'b1, lvtc_pkg::OFS_CTRL, 32'(m * 2 + 1));
      wt(2);
      `CHK({pump_run, use_ext_supply, pump_mult}, {2'h2, 3'(m)})
    end
    apb(1'b1, lvtc_pkg::OFS_CTRL, 32'hce);
    rd(lvtc_pkg::OFS_CTRL, 32'hce);
    apb(1'b1, lvtc_pkg::OFS_CTRL, 32'h0);
    wt(2);
    `CHK({pump_run, use_ext_supply, drive_code}, 12'h400)
    apb(1'b1, 12'h0f0, 32'hffffffff);
    `CHK(rerr, 1'b1)
    rd(12'h0f0, 32'h0);
    // Plain measurement: code timing, bypass, period, stop
    apb(1'b1, lvtc_pkg::OFS_CTRL, 32'h10);
    wstart();
    t0 = cyc;
    rd(lvtc_pkg::OFS_TEMP, 32'hff);
    wt(4);
    rd(lvtc_pkg::OFS_TEMP, 32'hff);
    rd(lvtc_pkg::OFS_TEMP, 32'h80);
    level <= 8'h40;
    wstart();
    `CHK(cyc - t0, PER)
    wt(MEAS + 3);
    rd(lvtc_pkg::OFS_TEMP, 32'h40);
    level <= 8'h20;
    apb(1'b1, lvtc_pkg::OFS_CTRL, 32'h0);
    wt(PER);
    rd(lvtc_pkg::OFS_TEMP, 32'h40);
    // Reset after the stop clears code and registers
    reset <= 1'b1;
    wt(2);
    reset <= 1'b0;
    rd(lvtc_pkg::OFS_TEMP, 32'hff);
    rd(lvtc_pkg::OFS_COMP, 32'h0);
    rd(lvtc_pkg::OFS_VPROG, 32'h0);
    // Filtered measurement: seed, then a damped step
    level <= 8'hc0;
    apb(1'b1, lvtc_pkg::OFS_CTRL, 32'h30);
    wstart();
    rd(lvtc_pkg::OFS_TEMP, 32'hff);
    wt(MEAS + 3);
    rd(lvtc_pkg::OFS_TEMP, 32'hc0);
    level <= 8'h40;
    wstart();
    wt(MEAS + 3);
    rd(lvtc_pkg::OFS_TEMP, 32'ha0);
    apb(1'b1, lvtc_pkg::OFS_CTRL, 32'h0);
    end_of_test();
  end
endmodule // lvtc_top_tb
